// *** hw/crd_completer_request_delivery.sv ***
// completer request framer: descriptor plus payload onto the request stream
`timescale 1ns/1ps
`default_nettype none
module crd_completer_request_delivery #(
  parameter int DATA_W = crd_pkg::DATA_W_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // configuration level, 1 selects address-aligned placement
  input wire logic addr_aligned_mode,
  // incoming request descriptor
  input wire logic desc_valid,
  output logic desc_ready,
  input wire logic [crd_pkg::DESC_W-1:0] desc_data,
  input wire logic desc_is_write,
  input wire logic [crd_pkg::CNT_W-1:0] desc_dword_count,
  input wire logic desc_zero_len,
  input wire logic [3:0] desc_head_mask,
  input wire logic [3:0] desc_tail_mask,
  // incoming write payload dwords
  input wire logic pay_valid,
  output logic pay_ready,
  input wire logic [crd_pkg::DW_BITS-1:0] pay_data,
  // request stream toward user logic
  output logic [DATA_W-1:0] req_stream_payload,
  output logic req_stream_valid,
  input wire logic req_stream_ready,
  output logic [DATA_W/crd_pkg::DW_BITS-1:0] req_stream_dword_keep,
  output logic req_stream_last,
  output logic [crd_pkg::SB_W-1:0] req_stream_sideband
);
  localparam int LANES = DATA_W / crd_pkg::DW_BITS;
  localparam int LANE_LOG = $clog2(LANES);
  localparam int NUM_W = LANE_LOG + 1;
  localparam int LVL_W = $clog2(crd_pkg::FIFO_DEPTH + 1);
  localparam int PAY_BASE = ((crd_pkg::DESC_DW + LANES - 1) / LANES) * LANES;
  localparam int READ_BEATS = (crd_pkg::DESC_DW + LANES - 1) / LANES;
  localparam int PW = crd_pkg::POS_W;

  function automatic logic [3:0] lane_mask(input int p, input int n, input logic zero,
                                           input logic [3:0] head, input logic [3:0] tail);
    if (p == 0) begin
      return zero ? crd_pkg::MASK_NONE : head;
    end else if (p == n - 1) begin
      return tail;
    end
    return crd_pkg::MASK_FULL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration pin synchroniser
  logic [1:0] align_sync_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      align_sync_ff <= crd_pkg::SYNC_RESET;
    end else begin
      align_sync_ff <= {align_sync_ff[0], addr_aligned_mode};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // payload buffer
  logic fifo_rd_ready;
  logic [NUM_W-1:0] fifo_rd_num;
  logic [LANES*crd_pkg::DW_BITS-1:0] fifo_peek;
  logic [LVL_W-1:0] fifo_level;

  crd_dword_fifo #(
    .W(crd_pkg::DW_BITS),
    .DEPTH(crd_pkg::FIFO_DEPTH),
    .PEEK(LANES)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_valid(pay_valid),
    .wr_ready(pay_ready),
    .wr_data(pay_data),
    .rd_valid(),
    .rd_ready(fifo_rd_ready),
    .rd_num(fifo_rd_num),
    .rd_data(fifo_peek),
    .rd_level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // packet header and walk position
  crd_pkg::crd_state_t state_ff, nxt_state;
  logic [crd_pkg::DESC_W-1:0] hdr_desc_ff, nxt_desc;
  logic hdr_wr_ff, nxt_wr;
  logic hdr_align_ff, nxt_align;
  logic hdr_zero_ff, nxt_zero;
  logic [3:0] hdr_head_ff, nxt_head;
  logic [3:0] hdr_tail_ff, nxt_tail;
  logic [PW-1:0] hdr_n_ff, nxt_n;
  logic [PW-1:0] hdr_gap_ff, nxt_gap;
  logic [PW-1:0] hdr_total_ff, nxt_total;
  logic [PW-1:0] pos_ff, nxt_pos;
  logic beat_adv;
  logic beat_last;

  // a write is taken only once its whole payload sits in the buffer
  assign desc_ready = (state_ff == crd_pkg::ST_IDLE) &&
                      (!desc_is_write || fifo_level >= LVL_W'(desc_dword_count));

  always_comb begin
    int gap_i;
    int n_i;
    gap_i = 0;
    n_i = 0;
    nxt_state = state_ff;
    nxt_desc = hdr_desc_ff;
    nxt_wr = hdr_wr_ff;
    nxt_align = hdr_align_ff;
    nxt_zero = hdr_zero_ff;
    nxt_head = hdr_head_ff;
    nxt_tail = hdr_tail_ff;
    nxt_n = hdr_n_ff;
    nxt_gap = hdr_gap_ff;
    nxt_total = hdr_total_ff;
    nxt_pos = pos_ff;
    if (state_ff == crd_pkg::ST_IDLE) begin
      if (desc_valid && desc_ready) begin
        n_i = desc_is_write ? int'(desc_dword_count) : 0;
        if (desc_is_write && align_sync_ff[1]) begin
          gap_i = PAY_BASE + int'(desc_data[crd_pkg::DESC_ADDR_LSB +: LANE_LOG])
                  - crd_pkg::DESC_DW;
        end
        nxt_state = crd_pkg::ST_SEND;
        nxt_desc = desc_data;
        nxt_wr = desc_is_write;
        nxt_align = align_sync_ff[1];
        nxt_zero = desc_zero_len;
        nxt_head = desc_head_mask;
        nxt_tail = desc_tail_mask;
        nxt_n = PW'(n_i);
        nxt_gap = PW'(gap_i);
        nxt_total = PW'(crd_pkg::DESC_DW + gap_i + n_i);
        nxt_pos = '0;
      end
    end else if (beat_adv) begin
      nxt_pos = pos_ff + PW'(LANES);
      if (beat_last) begin
        nxt_state = crd_pkg::ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= crd_pkg::ST_IDLE;
      hdr_desc_ff <= '0;
      hdr_wr_ff <= 1'b0;
      hdr_align_ff <= 1'b0;
      hdr_zero_ff <= 1'b0;
      hdr_head_ff <= '0;
      hdr_tail_ff <= '0;
      hdr_n_ff <= '0;
      hdr_gap_ff <= '0;
      hdr_total_ff <= '0;
      pos_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      hdr_desc_ff <= nxt_desc;
      hdr_wr_ff <= nxt_wr;
      hdr_align_ff <= nxt_align;
      hdr_zero_ff <= nxt_zero;
      hdr_head_ff <= nxt_head;
      hdr_tail_ff <= nxt_tail;
      hdr_n_ff <= nxt_n;
      hdr_gap_ff <= nxt_gap;
      hdr_total_ff <= nxt_total;
      pos_ff <= nxt_pos;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // beat assembly and output stage
  logic [DATA_W-1:0] out_data_ff, nxt_data, beat_data;
  logic [LANES-1:0] out_keep_ff, nxt_keep, beat_keep;
  logic out_last_ff, nxt_last;
  logic [crd_pkg::SB_W-1:0] out_sb_ff, nxt_sb;
  logic out_valid_ff, nxt_valid;
  logic out_wr_ff, nxt_out_wr;
  logic out_align_ff, nxt_out_align;
  logic [LANES*4-1:0] beat_be;

  // stream packed as lanes: descriptor, gap, payload
  always_comb begin
    int k;
    int base;
    int pops;
    int pay_start;
    k = 0;
    pay_start = crd_pkg::DESC_DW + int'(hdr_gap_ff);
    base = (int'(pos_ff) > pay_start) ? int'(pos_ff) : pay_start;
    pops = 0;
    beat_data = '0;
    beat_keep = '0;
    beat_be = '0;
    for (int j = 0; j < LANES; j++) begin
      k = int'(pos_ff) + j;
      if (k < crd_pkg::DESC_DW) begin
        beat_data[j*crd_pkg::DW_BITS +: crd_pkg::DW_BITS] = hdr_desc_ff[k*crd_pkg::DW_BITS +: crd_pkg::DW_BITS];
        beat_keep[j] = 1'b1;
      end else if (k < pay_start) begin
        beat_keep[j] = 1'b1;
      end else if (k < int'(hdr_total_ff)) begin
        beat_data[j*crd_pkg::DW_BITS +: crd_pkg::DW_BITS] =
          fifo_peek[(k - base)*crd_pkg::DW_BITS +: crd_pkg::DW_BITS];
        beat_keep[j] = 1'b1;
        beat_be[j*4 +: 4] = lane_mask(k - pay_start, int'(hdr_n_ff), hdr_zero_ff,
                                      hdr_head_ff, hdr_tail_ff);
        pops = pops + 1;
      end
    end
    beat_last = (int'(pos_ff) + LANES) >= int'(hdr_total_ff);
    beat_adv = (state_ff == crd_pkg::ST_SEND) && (!out_valid_ff || req_stream_ready);
    fifo_rd_ready = beat_adv && (pops != 0);
    fifo_rd_num = beat_adv ? NUM_W'(pops) : '0;
  end

  always_comb begin
    nxt_data = out_data_ff;
    nxt_keep = out_keep_ff;
    nxt_last = out_last_ff;
    nxt_sb = out_sb_ff;
    nxt_valid = out_valid_ff;
    nxt_out_wr = out_wr_ff;
    nxt_out_align = out_align_ff;
    if (!out_valid_ff || req_stream_ready) begin
      nxt_valid = state_ff == crd_pkg::ST_SEND;
      if (state_ff == crd_pkg::ST_SEND) begin
        nxt_data = beat_data;
        nxt_keep = beat_keep;
        nxt_last = beat_last;
        nxt_out_wr = hdr_wr_ff;
        nxt_out_align = hdr_align_ff;
        nxt_sb = '0;
        nxt_sb[crd_pkg::SB_HEAD_LSB +: 4] = hdr_head_ff;
        nxt_sb[crd_pkg::SB_TAIL_LSB +: 4] = hdr_tail_ff;
        nxt_sb[crd_pkg::SB_BE_LSB +: LANES*4] = beat_be;
        nxt_sb[crd_pkg::SB_SOP_BIT] = pos_ff == '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_data_ff <= '0;
      out_keep_ff <= '0;
      out_last_ff <= 1'b0;
      out_sb_ff <= '0;
      out_valid_ff <= 1'b0;
      out_wr_ff <= 1'b0;
      out_align_ff <= 1'b0;
    end else begin
      out_data_ff <= nxt_data;
      out_keep_ff <= nxt_keep;
      out_last_ff <= nxt_last;
      out_sb_ff <= nxt_sb;
      out_valid_ff <= nxt_valid;
      out_wr_ff <= nxt_out_wr;
      out_align_ff <= nxt_out_align;
    end
  end

  assign req_stream_payload = out_data_ff;
  assign req_stream_dword_keep = out_keep_ff;
  assign req_stream_last = out_last_ff;
  assign req_stream_sideband = out_sb_ff;
  assign req_stream_valid = out_valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // packet tracking for checks
  logic in_pkt_ff, nxt_in_pkt;
  logic [3:0] beat_cnt_ff, nxt_beat_cnt;
  logic acc;

  assign acc = out_valid_ff && req_stream_ready;

  always_comb begin
    nxt_in_pkt = in_pkt_ff;
    nxt_beat_cnt = beat_cnt_ff;
    if (acc) begin
      nxt_in_pkt = !out_last_ff;
      nxt_beat_cnt = out_last_ff ? '0 : beat_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_pkt_ff <= 1'b0;
      beat_cnt_ff <= '0;
    end else begin
      in_pkt_ff <= nxt_in_pkt;
      beat_cnt_ff <= nxt_beat_cnt;
    end
  end

  a_stall_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_valid_ff && !req_stream_ready |=> out_valid_ff && $stable(out_data_ff) && $stable(out_keep_ff)
      && $stable(out_last_ff) && $stable(out_sb_ff))
    else $error("stalled beat changed");

  a_valid_packet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_valid_ff && !out_last_ff |=> out_valid_ff)
    else $error("valid dropped inside a packet");

  a_sop_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_valid_ff |-> out_sb_ff[crd_pkg::SB_SOP_BIT] == !in_pkt_ff)
    else $error("start flag not on first beat");

  a_keep_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_valid_ff && !out_last_ff |-> &out_keep_ff)
    else $error("keep gap before last beat");

  a_keep_contig: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_valid_ff |-> out_keep_ff[0] && ((out_keep_ff & LANES'(out_keep_ff + 1'b1)) == '0))
    else $error("keep not contiguous");

  a_last_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && out_last_ff |=> !out_valid_ff || out_sb_ff[crd_pkg::SB_SOP_BIT])
    else $error("beat after last is not a start");

  a_read_beats: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && out_last_ff && !out_wr_ff |-> beat_cnt_ff == 4'(READ_BEATS - 1)
      && out_sb_ff[crd_pkg::SB_BE_LSB +: crd_pkg::SB_BE_W] == '0)
    else $error("read packet length wrong");

  a_aligned_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_valid_ff && out_sb_ff[crd_pkg::SB_SOP_BIT] && out_align_ff && out_wr_ff
      |-> out_sb_ff[crd_pkg::SB_BE_LSB +: crd_pkg::SB_BE_W] == '0 && !out_last_ff)
    else $error("payload shares descriptor beat");

  a_masks_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && !out_last_ff |=> $stable(out_sb_ff[crd_pkg::SB_HEAD_LSB +: 8]))
    else $error("masks changed within packet");
endmodule
`default_nettype wire

// *** hw/crd_dword_fifo.sv ***
// dword fifo with a multi-word peek window and multi-word pop
`timescale 1ns/1ps
`default_nettype none
module crd_dword_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32,
  parameter int PEEK = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  // drain side
  output logic rd_valid,
  input wire logic rd_ready,
  input wire logic [$clog2(PEEK):0] rd_num,
  output logic [PEEK*W-1:0] rd_data,
  output logic [$clog2(DEPTH+1)-1:0] rd_level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [CW-1:0] count_ff, nxt_count;
  logic [CW-1:0] pop_n;
  logic push;

  ////////////////////////////////////////////////////////////////////////////
  assign wr_ready = count_ff < CW'(DEPTH);
  assign rd_valid = count_ff != '0;
  assign rd_level = count_ff;
  assign push = wr_valid && wr_ready;

  generate
    for (genvar i = 0; i < PEEK; i++) begin : g_peek
      assign rd_data[i*W +: W] = mem[rd_ptr_ff + AW'(i)];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    pop_n = rd_ready ? CW'(rd_num) : '0;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff + AW'(pop_n);
    nxt_count = count_ff + CW'(push) - pop_n;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end

  // storage carries no reset
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_ff] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// *** hw/crd_pkg.sv ***
// shared constants and types for the completer request delivery block
package crd_pkg;
  localparam int DW_BITS = 32;
  localparam int DESC_DW = 4;
  localparam int DESC_W = 128;
  localparam int DESC_ADDR_LSB = 2;
  localparam int SB_HEAD_LSB = 0;
  localparam int SB_TAIL_LSB = 4;
  localparam int SB_BE_LSB = 8;
  localparam int SB_BE_W = 32;
  localparam int SB_SOP_BIT = 40;
  localparam int SB_W = 41;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam int POS_W = 8;
  localparam int DATA_W_DEFAULT = 256;
  localparam logic [3:0] MASK_FULL = 4'hF;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  typedef enum logic {ST_IDLE, ST_SEND} crd_state_t;
endpackage

// *** verif/crd_sink.sv ***
// model of the user logic sinking the request stream
`timescale 1ns/1ps
`default_nettype none
module crd_sink #(
  parameter int DATA_W = 256
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // request stream from the device
  input wire logic [DATA_W-1:0] req_stream_payload,
  input wire logic req_stream_valid,
  output logic req_stream_ready,
  input wire logic [DATA_W/32-1:0] req_stream_dword_keep,
  input wire logic req_stream_last,
  input wire logic [crd_pkg::SB_W-1:0] req_stream_sideband,
  // bench control
  input wire logic stall_en,
  input wire logic clr
);
  localparam int VW = DATA_W + DATA_W/32 + 1 + crd_pkg::SB_W;
  logic [DATA_W-1:0] cap_pay [0:7];
  logic [DATA_W/32-1:0] cap_keep [0:7];
  logic cap_last [0:7];
  logic [crd_pkg::SB_W-1:0] cap_sb [0:7];
  int beats;
  int hold_err;
  logic [1:0] ph;
  logic need;
  logic held;
  logic [VW-1:0] view;
  logic [VW-1:0] cur;
  assign cur = {req_stream_payload, req_stream_dword_keep, req_stream_last, req_stream_sideband};
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      req_stream_ready <= 1'b0;
      need <= 1'b0;
      held <= 1'b0;
      beats <= 0;
      hold_err <= 0;
    end else begin
      ph <= ph + 2'h1;
      // stall three cycles of four when asked
      req_stream_ready <= !stall_en || (ph == 2'h2);
      held <= req_stream_valid && !req_stream_ready;
      need <= req_stream_valid && (!req_stream_ready || !req_stream_last);
      view <= cur;
      if ((need && !req_stream_valid) || (held && view !== cur)) begin
        hold_err <= hold_err + 1;
      end
      if (clr) begin
        beats <= 0;
      end else if (req_stream_valid && req_stream_ready && beats < 8) begin
        cap_pay[beats] <= req_stream_payload;
        cap_keep[beats] <= req_stream_dword_keep;
        cap_last[beats] <= req_stream_last;
        cap_sb[beats] <= req_stream_sideband;
        beats <= beats + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_completer_request_delivery.sv ***
// self-checking bench for the completer request framer
`timescale 1ns/1ps
`default_nettype none
module tb_completer_request_delivery;
  localparam int DW = 256;
  localparam int LN = DW/32;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic addr_aligned_mode = 1'b0;
  logic desc_valid = 1'b0;
  logic desc_ready;
  logic [127:0] desc_data = 128'h0;
  logic desc_is_write = 1'b0;
  logic [5:0] desc_dword_count = 6'h01;
  logic desc_zero_len = 1'b0;
  logic [3:0] desc_head_mask = 4'h0;
  logic [3:0] desc_tail_mask = 4'h0;
  logic pay_valid = 1'b0;
  logic pay_ready;
  logic [31:0] pay_data = 32'h0;
  logic [DW-1:0] req_stream_payload;
  logic req_stream_valid;
  logic req_stream_ready;
  logic [LN-1:0] req_stream_dword_keep;
  logic req_stream_last;
  logic [40:0] req_stream_sideband;
  logic stall_en = 1'b0;
  logic clr = 1'b0;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  always #4 clk_sys = ~clk_sys;

  crd_completer_request_delivery #(.DATA_W(DW)) crd_completer_request_delivery_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr_aligned_mode(addr_aligned_mode),
    .desc_valid(desc_valid), .desc_ready(desc_ready), .desc_data(desc_data), .desc_is_write(desc_is_write),
    .desc_dword_count(desc_dword_count), .desc_zero_len(desc_zero_len), .desc_head_mask(desc_head_mask),
    .desc_tail_mask(desc_tail_mask), .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data),
    .req_stream_payload(req_stream_payload), .req_stream_valid(req_stream_valid),
    .req_stream_ready(req_stream_ready), .req_stream_dword_keep(req_stream_dword_keep),
    .req_stream_last(req_stream_last), .req_stream_sideband(req_stream_sideband));

  crd_sink #(.DATA_W(DW)) crd_sink_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .req_stream_payload(req_stream_payload),
    .req_stream_valid(req_stream_valid), .req_stream_ready(req_stream_ready),
    .req_stream_dword_keep(req_stream_dword_keep), .req_stream_last(req_stream_last),
    .req_stream_sideband(req_stream_sideband), .stall_en(stall_en), .clr(clr));

  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic [40:0] got, input logic [40:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////
  // one packet: buffer payload, offer descriptor, judge captured beats
  task automatic run_pkt(input logic wr, input int cnt, input logic zl, input logic al, input logic [2:0] adw,
                         input logic [3:0] hd, input logic [3:0] tl);
    int st;
    int en;
    int nb;
    int p;
    int k;
    logic [127:0] d;
    logic [3:0] be;
    logic [31:0] ed;
    logic [40:0] esb;
    logic [LN-1:0] ek;
    d = {32'hD3D3D3D3, 32'hD2D2D2D2, 32'hD1D1D1D1, 24'hD0D0D0, 3'h0, adw, 2'h0};
    st = al ? LN + adw : 4;
    en = wr ? st + cnt : 4;
    nb = (en + LN - 1) / LN;
    @(posedge clk_sys);
    addr_aligned_mode <= al;
    clr <= 1'b1;
    // mode pin synchroniser settles
    repeat (4) @(posedge clk_sys);
    clr <= 1'b0;
    for (int i = 0; i < (wr ? cnt : 0); i++) begin
      pay_valid <= 1'b1;
      pay_data <= 32'hA0000000 | i;
      @(negedge clk_sys);
      while (!pay_ready) @(negedge clk_sys);
      @(posedge clk_sys);
    end
    pay_valid <= 1'b0;
    desc_valid <= 1'b1;
    desc_data <= d;
    desc_is_write <= wr;
    desc_dword_count <= 6'(cnt);
    desc_zero_len <= zl;
    desc_head_mask <= hd;
    desc_tail_mask <= tl;
    @(negedge clk_sys);
    while (!desc_ready) @(negedge clk_sys);
    @(posedge clk_sys);
    desc_valid <= 1'b0;
    while (crd_sink_inst.beats < nb) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    chk_flag(41'(crd_sink_inst.beats), 41'(nb));
    for (int b = 0; b < nb; b++) begin
      ek = '0;
      esb = {b == 0, 32'h0, tl, hd};
      for (int l = 0; l < LN; l++) begin
        p = b * LN + l;
        k = p - st;
        if (p < en) begin
          ek[l] = 1'b1;
          ed = (p < 4) ? d[32*p +: 32] : ((p < st) ? 32'h0 : (32'hA0000000 | k));
          be = (p < st) ? 4'h0 : ((k == 0) ? (zl ? 4'h0 : hd) : ((k == cnt - 1) ? tl : 4'hF));
          esb[8 + 4*l +: 4] = be;
          chk_data(crd_sink_inst.cap_pay[b][32*l +: 32], ed);
        end
      end
      chk_flag(41'(crd_sink_inst.cap_keep[b]), 41'(ek));
      chk_flag(crd_sink_inst.cap_sb[b], esb);
      chk_flag(41'(crd_sink_inst.cap_last[b]), 41'(b == nb - 1));
    end
    chk_flag(41'(crd_sink_inst.hold_err), 41'h0);
  endtask

  task automatic t_read;
    run_pkt(1'b0, 1, 1'b0, 1'b0, 3'h0, 4'hF, 4'h0);
  endtask
  task automatic t_dw_write;
    run_pkt(1'b1, 6, 1'b0, 1'b0, 3'h5, 4'hE, 4'h3);
  endtask
  task automatic t_al_short;
    run_pkt(1'b1, 2, 1'b0, 1'b1, 3'h3, 4'h6, 4'h1);
  endtask
  task automatic t_al_long;
    run_pkt(1'b1, 11, 1'b0, 1'b1, 3'h7, 4'h8, 4'h7);
  endtask
  task automatic t_zero_len;
    run_pkt(1'b1, 1, 1'b1, 1'b1, 3'h1, 4'hF, 4'h0);
  endtask
  task automatic t_stall;
    stall_en <= 1'b1;
    run_pkt(1'b1, 9, 1'b0, 1'b1, 3'h2, 4'hC, 4'h3);
    run_pkt(1'b0, 1, 1'b0, 1'b0, 3'h0, 4'h3, 4'h0);
    stall_en <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk_flag(41'(req_stream_valid), 41'h0);
    chk_flag(41'(desc_ready), 41'h1);
    chk_flag(41'(pay_ready), 41'h1);
    t_read();
    t_dw_write();
    t_al_short();
    t_al_long();
    t_zero_len();
    t_stall();
    complete_run();
  end
endmodule
`default_nettype wire
